// >>> scb_pkg.sv
// Constants, types and helper functions for the serial control block
package scb_pkg;

  localparam logic [7:0] OFS_CTL1   = 8'h00;
  localparam logic [7:0] OFS_CTL2   = 8'h04;
  localparam logic [7:0] OFS_CTL3   = 8'h08;
  localparam logic [7:0] OFS_STAT   = 8'h0c;
  localparam logic [7:0] OFS_DATA   = 8'h10;
  localparam logic [7:0] CTL_RST    = 8'h00;
  localparam logic [3:0] LEN_SHORT  = 4'ha;
  localparam logic [3:0] LEN_LONG   = 4'hb;
  localparam logic [3:0] OS_LAST    = 4'hf;
  localparam logic [3:0] OS_MID     = 4'h7;
  localparam int unsigned OS_DIV_DEF = 27;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_DATA = 3'b001,
    TX_PRE  = 3'b010,
    TX_BRK  = 3'b011,
    TX_MARK = 3'b100
  } scb_tx_st_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10
  } scb_rx_st_t;

  typedef struct packed {
    logic loopback_select;
    logic serial_unit_enable;
    logic tx_polarity_flip;
    logic char_length_select;
    logic rouse_condition_select;
    logic quiet_count_start;
    logic parity_on;
    logic parity_odd_select;
  } scb_ctl1_t;

  typedef struct packed {
    logic tx_irq_enable;
    logic tx_done_irq_enable;
    logic rx_irq_enable;
    logic line_quiet_irq_enable;
    logic tx_enable;
    logic rx_enable;
    logic rx_standby;
    logic send_break_req;
  } scb_ctl2_t;

  typedef struct packed {
    logic tx_cpu_irq;
    logic tx_dma_req;
    logic rx_cpu_irq;
    logic rx_dma_req;
  } scb_req_t;

  typedef struct packed {
    scb_ctl1_t  ctl1;
    scb_ctl2_t  ctl2;
    logic       tx_dma_enable;
    logic       rx_dma_enable;
    logic       tx_bit8;
    logic [7:0] txbuf;
    logic       tx_buffer_empty_flag;
    logic       pre_pend;
    scb_tx_st_t tx_st;
    logic [10:0] tx_frame;
    logic [3:0] tx_bitn;
    logic [3:0] tx_os;
    logic       tx_line;
    logic       tx_pin;
    scb_rx_st_t rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_bitn;
    logic [10:0] rx_sh;
    logic [8:0] rx_data;
    logic       rx_full_flag;
    logic       line_quiet_flag;
    logic       parity_err;
    logic       frame_err;
    logic       overrun;
    logic       armed;
    logic [3:0] q_cnt;
    logic [3:0] q_os;
    logic [31:0] prdata;
  } scb_state_t;

  function automatic logic [3:0] frame_len(input logic nine);
    return nine ? LEN_LONG : LEN_SHORT;
  endfunction

  function automatic logic par_bit(input logic [8:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

endpackage

// >>> scb_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for the receive pin
module scb_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Level in and out
  input  wire logic d,
  output logic      q
);
  logic meta_q;

  // Idle line is high, so reset to one avoids a false start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// >>> scb_tick.sv
`timescale 1ns/1ps
// Oversampling tick generator, sixteen ticks per bit
module scb_tick
  import scb_pkg::*;
#(
  parameter int unsigned OS_DIV = OS_DIV_DEF
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control and tick
  input  wire logic enable,
  output logic      tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } scb_tick_st_t;

  scb_tick_st_t s_q;
  scb_tick_st_t s_d;

  if (OS_DIV < 2 || OS_DIV > 65535) begin : g_bad_div
    $error("OS_DIV out of range");
  end

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!enable) begin
      s_d.cnt = 16'h0000;
    end else if (s_q.cnt == 16'(OS_DIV - 1)) begin
      s_d.cnt  = 16'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// >>> scb_serial_ctl.sv
`timescale 1ns/1ps
// Serial transceiver control: registers, transmitter, receiver, request steering
module scb_serial_ctl
  import scb_pkg::*;
#(
  parameter int unsigned OS_DIV = OS_DIV_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        rx_pin,
  output logic             tx_pin,
  // Interrupt and DMA requests
  output scb_req_t         req
);

  scb_state_t  s_q;
  scb_state_t  s_d;
  logic        os_tick;
  logic        rx_sync;
  logic        rx_line;
  logic        tx_done_flag;
  logic        wr_en;
  logic        rd_en;
  logic        tx_bound;
  logic [3:0]  len;
  logic [8:0]  pay;
  logic [10:0] frm;
  logic [10:0] nsh;
  logic [8:0]  rpay;
  logic        rmsb;
  logic        quiet_hit;
  logic        woke;
  logic        ld_data;

  function automatic logic addr_ok(input logic [7:0] a);
    return a == OFS_CTL1 || a == OFS_CTL2 || a == OFS_CTL3 || a == OFS_STAT || a == OFS_DATA;
  endfunction

  scb_sync u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (rx_pin),
    .q       (rx_sync)
  );

  // Baud generator runs only while the unit is on
  scb_tick #(.OS_DIV(OS_DIV)) u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .enable  (s_q.ctl1.serial_unit_enable),
    .tick    (os_tick)
  );

  // Pin is cut off in loopback; receiver hears the driven pin level
  assign rx_line = s_q.ctl1.loopback_select ? s_q.tx_pin : rx_sync;

  assign wr_en   = psel && penable && pwrite && addr_ok(paddr);
  assign rd_en   = psel && penable && !pwrite && addr_ok(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok(paddr);
  assign prdata  = s_q.prdata;
  assign tx_pin  = s_q.tx_pin;

  // Done: empty, idle, and no preamble or break waiting
  // Unit off forces done even while a break request is left set
  assign tx_done_flag = s_q.tx_buffer_empty_flag && s_q.tx_st == TX_IDLE && !s_q.pre_pend
                        && !(s_q.ctl1.serial_unit_enable && s_q.ctl2.tx_enable
                             && s_q.ctl2.send_break_req);

  // Request steering
  always_comb begin
    req.tx_cpu_irq = s_q.ctl1.serial_unit_enable
                     && ((s_q.ctl2.tx_irq_enable && !s_q.tx_dma_enable
                          && s_q.tx_buffer_empty_flag)
                         || (s_q.ctl2.tx_done_irq_enable && tx_done_flag));
    req.tx_dma_req = s_q.ctl1.serial_unit_enable && s_q.ctl2.tx_irq_enable
                     && s_q.tx_dma_enable && s_q.tx_buffer_empty_flag;
    // Receiver DMA mode silences every receiver CPU request
    req.rx_cpu_irq = !s_q.ctl2.rx_standby && !s_q.rx_dma_enable
                     && ((s_q.ctl2.rx_irq_enable && s_q.rx_full_flag)
                         || (s_q.ctl2.line_quiet_irq_enable && s_q.line_quiet_flag));
    req.rx_dma_req = !s_q.ctl2.rx_standby && s_q.ctl2.rx_irq_enable
                     && s_q.rx_dma_enable && s_q.rx_full_flag;
  end

  always_comb begin
    s_d       = s_q;
    len       = frame_len(s_q.ctl1.char_length_select);
    tx_bound  = os_tick && s_q.tx_os == OS_LAST;
    pay       = 9'h000;
    frm       = 11'h7ff;
    nsh       = {rx_line, s_q.rx_sh[10:1]};
    rpay      = s_q.ctl1.char_length_select ? nsh[9:1] : {1'b0, nsh[9:2]};
    rmsb      = s_q.ctl1.char_length_select ? rpay[8] : rpay[7];
    quiet_hit = 1'b0;
    woke      = 1'b0;
    ld_data   = 1'b0;

    // Register reads latch in the setup cycle, so prdata is a flop
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFS_CTL1: s_d.prdata = {24'h000000, s_q.ctl1};
        OFS_CTL2: s_d.prdata = {24'h000000, s_q.ctl2};
        OFS_CTL3: s_d.prdata = {29'h00000000, s_q.tx_bit8, s_q.rx_dma_enable,
                                s_q.tx_dma_enable};
        OFS_STAT: s_d.prdata = {25'h0000000, s_q.overrun, s_q.frame_err, s_q.parity_err,
                                s_q.line_quiet_flag, s_q.rx_full_flag, tx_done_flag,
                                s_q.tx_buffer_empty_flag};
        OFS_DATA: s_d.prdata = {23'h000000, s_q.rx_data};
        default:  s_d.prdata = 32'h00000000;
      endcase
    end

    // Data read clears receiver flags; later sets in this process win
    if (rd_en && paddr == OFS_DATA) begin
      s_d.rx_full_flag    = 1'b0;
      s_d.line_quiet_flag = 1'b0;
      s_d.parity_err      = 1'b0;
      s_d.frame_err       = 1'b0;
      s_d.overrun         = 1'b0;
    end

    if (wr_en) begin
      unique case (paddr)
        OFS_CTL1: s_d.ctl1 = pwdata[7:0];
        OFS_CTL2: begin
          s_d.ctl2 = pwdata[7:0];
          if (!s_q.ctl1.serial_unit_enable) begin
            s_d.ctl2.tx_enable = s_q.ctl2.tx_enable;
            s_d.ctl2.rx_enable = s_q.ctl2.rx_enable;
          end
          // Rising enable queues a preamble or, mid-frame, an idle character
          if (s_d.ctl2.tx_enable && !s_q.ctl2.tx_enable) begin
            s_d.pre_pend             = 1'b1;
            s_d.tx_buffer_empty_flag = 1'b1;
          end
        end
        OFS_CTL3: begin
          s_d.tx_dma_enable = pwdata[0];
          s_d.rx_dma_enable = pwdata[1];
          s_d.tx_bit8       = pwdata[2];
        end
        OFS_DATA: begin
          s_d.txbuf                = pwdata[7:0];
          s_d.tx_buffer_empty_flag = 1'b0;
        end
        default: s_d.txbuf = s_q.txbuf;
      endcase
    end

    if (!s_d.ctl2.tx_enable) begin
      s_d.pre_pend = 1'b0;
    end

    // Transmitter, one bit per sixteen ticks
    if (os_tick) begin
      s_d.tx_os = s_q.tx_os + 4'h1;
    end
    if (tx_bound) begin
      if (s_q.tx_bitn != 4'h0) begin
        s_d.tx_line  = s_q.tx_frame[0];
        s_d.tx_frame = {1'b1, s_q.tx_frame[10:1]};
        s_d.tx_bitn  = s_q.tx_bitn - 4'h1;
      end else if (!s_d.ctl2.tx_enable) begin
        s_d.tx_st   = TX_IDLE;
        s_d.tx_line = 1'b1;
      end else if (s_d.ctl2.send_break_req) begin
        // Break outranks a queued preamble
        s_d.tx_st    = TX_BRK;
        s_d.pre_pend = 1'b0;
        s_d.tx_line  = 1'b0;
        s_d.tx_frame = 11'h000;
        s_d.tx_bitn  = len - 4'h1;
      end else if (s_q.tx_st == TX_BRK) begin
        s_d.tx_st   = TX_MARK;
        s_d.tx_line = 1'b1;
      end else if (s_d.pre_pend) begin
        s_d.tx_st    = TX_PRE;
        s_d.pre_pend = 1'b0;
        s_d.tx_line  = 1'b1;
        s_d.tx_frame = 11'h7ff;
        s_d.tx_bitn  = len - 4'h1;
      end else if (!s_d.tx_buffer_empty_flag) begin
        ld_data = 1'b1;
        // Buffer as written this cycle, so a same-edge write is not lost
        if (s_q.ctl1.char_length_select) begin
          pay = {s_q.ctl1.parity_on ? par_bit({1'b0, s_d.txbuf}, s_q.ctl1.parity_odd_select)
                                    : s_q.tx_bit8, s_d.txbuf};
          frm = {1'b1, pay, 1'b0};
        end else begin
          pay = {1'b0, s_q.ctl1.parity_on
                       ? par_bit({2'b00, s_d.txbuf[6:0]}, s_q.ctl1.parity_odd_select)
                       : s_d.txbuf[7], s_d.txbuf[6:0]};
          frm = {2'b11, pay[7:0], 1'b0};
        end
        s_d.tx_st                = TX_DATA;
        s_d.tx_buffer_empty_flag = 1'b1;
        s_d.tx_line              = frm[0];
        s_d.tx_frame             = {1'b1, frm[10:1]};
        s_d.tx_bitn              = len - 4'h1;
      end else begin
        s_d.tx_st   = TX_IDLE;
        s_d.tx_line = 1'b1;
      end
    end

    // Receiver; disable leaves every flag as it stands
    if (!(s_q.ctl1.serial_unit_enable && s_q.ctl2.rx_enable)) begin
      s_d.rx_st = RX_IDLE;
      s_d.rx_os = 4'h0;
      s_d.q_os  = 4'h0;
    end else if (os_tick) begin
      unique case (s_q.rx_st)
        RX_IDLE: begin
          if (rx_line) begin
            s_d.q_os = s_q.q_os + 4'h1;
            if (s_q.q_os == OS_LAST && s_q.q_cnt != len) begin
              s_d.q_cnt = s_q.q_cnt + 4'h1;
              quiet_hit = (s_q.q_cnt + 4'h1) == len;
            end
          end else begin
            s_d.rx_st = RX_START;
            s_d.rx_os = 4'h0;
            s_d.q_os  = 4'h0;
          end
        end
        RX_START: begin
          s_d.rx_os = s_q.rx_os + 4'h1;
          if (s_q.rx_os == OS_MID) begin
            // A high line at mid-start is a glitch, not a frame
            s_d.rx_st   = rx_line ? RX_IDLE : RX_BITS;
            s_d.rx_os   = 4'h0;
            s_d.rx_bitn = len - 4'h1;
            s_d.q_cnt   = 4'h0;
          end
        end
        RX_BITS: begin
          s_d.rx_os = s_q.rx_os + 4'h1;
          if (s_q.rx_os == OS_LAST) begin
            s_d.rx_sh   = nsh;
            s_d.rx_bitn = s_q.rx_bitn - 4'h1;
            if (!rx_line) begin
              s_d.q_cnt = 4'h0;
            end else if (!s_q.ctl1.quiet_count_start && s_q.q_cnt != len) begin
              s_d.q_cnt = s_q.q_cnt + 4'h1;
            end
            if (s_q.rx_bitn == 4'h1) begin
              s_d.rx_st = RX_IDLE;
              s_d.q_os  = 4'h0;
              if (s_q.ctl1.quiet_count_start) begin
                s_d.q_cnt = 4'h0;
              end
              woke = s_q.ctl2.rx_standby && s_q.ctl1.rouse_condition_select && rmsb;
              if (!s_q.ctl2.rx_standby || woke) begin
                s_d.armed = 1'b1;
                if (s_q.rx_full_flag) begin
                  s_d.overrun = 1'b1;
                end else begin
                  s_d.rx_data      = rpay;
                  s_d.rx_full_flag = 1'b1;
                  s_d.parity_err   = s_q.ctl1.parity_on
                                     && par_bit(rpay, s_q.ctl1.parity_odd_select);
                  s_d.frame_err    = !rx_line;
                end
              end
            end
          end
        end
        default: s_d.rx_st = RX_IDLE;
      endcase
    end

    if (quiet_hit) begin
      if (s_q.ctl2.rx_standby && !s_q.ctl1.rouse_condition_select) begin
        woke = 1'b1;
      end else if (s_q.armed && !s_q.ctl2.rx_standby) begin
        s_d.line_quiet_flag = 1'b1;
        s_d.armed           = 1'b0;
      end
    end
    if (woke) begin
      s_d.ctl2.rx_standby = 1'b0;
    end

    // Unit off: transmitter forced empty and idle
    if (!s_d.ctl1.serial_unit_enable) begin
      s_d.tx_buffer_empty_flag = 1'b1;
      s_d.pre_pend             = 1'b0;
      s_d.tx_st                = TX_IDLE;
      s_d.tx_bitn              = 4'h0;
      s_d.tx_os                = 4'h0;
      s_d.tx_line              = 1'b1;
    end
    s_d.tx_pin = s_d.tx_line ^ s_d.ctl1.tx_polarity_flip;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q                      <= '0;
      s_q.ctl1                 <= CTL_RST;
      s_q.ctl2                 <= CTL_RST;
      s_q.tx_buffer_empty_flag <= 1'b1;
      s_q.tx_line              <= 1'b1;
      s_q.tx_pin               <= 1'b1;
      s_q.rx_sh                <= 11'h7ff;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_loop_route:  assert property (s_q.ctl1.loopback_select |-> rx_line == tx_pin)
    else $error("loopback does not route transmitter to receiver");
  a_unit_off:    assert property (!s_q.ctl1.serial_unit_enable |-> tx_done_flag
                                  && !req.tx_cpu_irq && !req.tx_dma_req)
    else $error("disabled unit not empty or still requesting");
  a_pol_flip:    assert property (tx_pin == (s_q.tx_line ^ s_q.ctl1.tx_polarity_flip))
    else $error("transmit polarity wrong");
  a_start_low:   assert property ($rose(ld_data) |=> !s_q.tx_line && s_q.tx_st == TX_DATA)
    else $error("data frame does not open with low start bit");
  a_frame_len:   assert property (ld_data |=> s_q.tx_bitn == len - 4'h1)
    else $error("frame length count wrong");
  a_tx_steer:    assert property (req.tx_dma_req |-> s_q.ctl2.tx_irq_enable
                                  && s_q.tx_dma_enable && !req.tx_cpu_irq
                                  || s_q.ctl2.tx_done_irq_enable)
    else $error("transmit DMA request without its enables");
  a_tc_irq:      assert property (s_q.ctl1.serial_unit_enable && s_q.ctl2.tx_done_irq_enable
                                  && tx_done_flag |-> req.tx_cpu_irq)
    else $error("done flag did not raise transmitter request");
  a_rx_dma_mask: assert property (s_q.rx_dma_enable |-> !req.rx_cpu_irq)
    else $error("receiver CPU request during DMA mode");
  a_pre_queue:   assert property (s_q.pre_pend && tx_bound && s_q.tx_bitn == 4'h0
                                  && s_q.ctl1.serial_unit_enable && s_q.ctl2.tx_enable
                                  && !s_q.ctl2.send_break_req && s_q.tx_st != TX_BRK
                                  && !wr_en |=> s_q.tx_st == TX_PRE)
    else $error("preamble not started at bit boundary");
  a_en_guard:    assert property (wr_en && paddr == OFS_CTL2
                                  && !s_q.ctl1.serial_unit_enable
                                  |=> $stable(s_q.ctl2.tx_enable))
    else $error("transmit enable changed while unit off");
  a_load_empty:  assert property (ld_data |=> s_q.tx_buffer_empty_flag)
    else $error("hand-over did not set empty flag");
  a_done_def:    assert property (tx_done_flag |-> s_q.tx_buffer_empty_flag
                                  && s_q.tx_st == TX_IDLE)
    else $error("done flag while shifting");
  a_standby:     assert property (s_q.ctl2.rx_standby |-> !req.rx_cpu_irq
                                  && !req.rx_dma_req)
    else $error("receiver request during standby");

  c_break:    cover property (s_q.tx_st == TX_BRK ##[1:400] s_q.tx_st == TX_MARK);
  c_rx_char:  cover property ($rose(s_q.rx_full_flag));
  c_quiet:    cover property ($rose(s_q.line_quiet_flag));
  c_wake:     cover property ($fell(s_q.ctl2.rx_standby));
endmodule

// >>> scb_remote.sv
// Remote serial transceiver model for the far end of the link
`timescale 1ns/1ps
module scb_remote #(
  parameter int BITC = 32
) (
  // Clock and lines
  input  wire logic clk,
  input  wire logic tx_pin,
  output logic      rx_pin
);
  logic [8:0] last;
  int         n_rx = 0;
  // Line rests at mark between frames
  initial rx_pin = 1'b1;
  // Start, eight bits LSB first, stop
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin <= f[i];
      repeat (BITC) @(posedge clk);
    end
  endtask
  // Mid-bit sampling; ones-only preamble never triggers it
  always begin
    @(negedge tx_pin);
    repeat (BITC / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BITC) @(posedge clk);
      last[i] = tx_pin;
    end
    n_rx++;
  end
endmodule

// >>> uart_control_registers_tb.sv
// Self-checking bench for the serial control block
`timescale 1ns/1ps
module uart_control_registers_tb
  import scb_pkg::*;
;
  // Small divider keeps each bit at 32 clocks
  localparam int OSD  = 2;
  localparam int BITC = 16 * OSD;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_pin;
  logic        tx_pin;
  scb_req_t    req;
  logic [31:0] rd;
  logic        err;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #10 clk = ~clk;

  scb_serial_ctl #(.OS_DIV(OSD)) dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .req(req)
  );
  scb_remote #(.BITC(BITC)) remote (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin));

  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // A hang here is ended by the bench timeout
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
    end while ((rd & m) !== v);
  endtask

  // Requests settle after the write edge, so look half a cycle later
  task automatic creq(input logic [3:0] v);
    @(negedge clk);
    chk({28'h0, req}, {28'h0, v});
  endtask

  task automatic t_reset();
    apb(1'b0, OFS_CTL1, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_CTL2, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd & 32'h3, 32'h3);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_steer();
    wr(OFS_CTL2, 32'h0c);
    apb(1'b0, OFS_CTL2, 32'h0);
    chk(rd, 32'h0);
    wr(OFS_CTL2, 32'hc0);
    creq(4'b0000);
    wr(OFS_CTL1, 32'h40);
    creq(4'b1000);
    wr(OFS_CTL3, 32'h1);
    creq(4'b1100);
    wr(OFS_CTL2, 32'h80);
    creq(4'b0100);
    wr(OFS_CTL3, 32'h0);
    creq(4'b1000);
    wr(OFS_CTL2, 32'h00);
    creq(4'b0000);
    wr(OFS_CTL2, 32'h40);
    creq(4'b1000);
    wr(OFS_CTL1, 32'h00);
    creq(4'b0000);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd & 32'h3, 32'h3);
    wr(OFS_CTL2, 32'h00);
    $display("test steer done");
  endtask

  task automatic t_tx();
    int n;
    wr(OFS_CTL1, 32'h40);
    wr(OFS_CTL2, 32'h08);
    n = remote.n_rx;
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd & 32'h3, 32'h1);
    wr(OFS_DATA, 32'ha5);
    poll(32'h2, 32'h2);
    chk(32'(remote.n_rx - n), 32'h1);
    chk(remote.last, 32'h1a5);
    // Parity type only changes between characters
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTL1, 32'h42 | i);
      wr(OFS_DATA, 32'h35);
      poll(32'h2, 32'h2);
      chk(remote.last, i ? 32'h1b5 : 32'h135);
    end
    $display("test transmit done");
  endtask

  task automatic t_loop();
    wr(OFS_CTL1, 32'hc0);
    wr(OFS_CTL2, 32'h2c);
    wr(OFS_DATA, 32'h5a);
    fork
      remote.send(8'h00);
    join_none
    poll(32'h4, 32'h4);
    creq(4'b0010);
    wr(OFS_CTL3, 32'h2);
    creq(4'b0001);
    wr(OFS_CTL2, 32'h28);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd & 32'h1ff, 32'h05a);
    wr(OFS_CTL3, 32'h0);
    wait fork;
    $display("test loopback done");
  endtask

  task automatic t_rx();
    wr(OFS_CTL1, 32'h43);
    wr(OFS_CTL2, 32'h24);
    remote.send(8'hc3);
    poll(32'h4, 32'h4);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd & 32'h34, 32'h14);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd & 32'h1ff, 32'h0c3);
    $display("test receive done");
  endtask

  task automatic t_wake();
    wr(OFS_CTL1, 32'h48);
    wr(OFS_CTL2, 32'h26);
    remote.send(8'h12);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(rd & 32'h4, 32'h0);
    remote.send(8'h92);
    poll(32'h4, 32'h4);
    apb(1'b0, OFS_CTL2, 32'h0);
    chk(rd, 32'h24);
    apb(1'b0, OFS_DATA, 32'h0);
    chk(rd & 32'h1ff, 32'h092);
    wr(OFS_CTL2, 32'h14);
    poll(32'h8, 32'h8);
    creq(4'b0010);
    wr(OFS_CTL3, 32'h2);
    creq(4'b0000);
    wr(OFS_CTL3, 32'h0);
    apb(1'b0, OFS_DATA, 32'h0);
    $display("test wake done");
  endtask

  task automatic t_brk();
    int k;
    wr(OFS_CTL2, 32'h09);
    repeat (2 * BITC) @(posedge clk);
    k = 0;
    repeat (16 * BITC) begin
      @(posedge clk);
      k += tx_pin;
    end
    chk(32'(k), 32'h0);
    wr(OFS_CTL2, 32'h08);
    poll(32'h2, 32'h2);
    chk(remote.last, 32'h000);
    wr(OFS_DATA, 32'h3c);
    repeat (3 * BITC) @(posedge clk);
    wr(OFS_CTL2, 32'h00);
    poll(32'h2, 32'h2);
    chk(remote.last, 32'h13c);
    chk({31'h0, tx_pin}, 32'h1);
    $display("test break done");
  endtask

  task automatic t_flip();
    wr(OFS_CTL1, 32'h60);
    repeat (BITC) @(posedge clk);
    chk({31'h0, tx_pin}, 32'h0);
    $display("test polarity done");
  endtask

  // Whole run is near 4000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_steer();
    t_tx();
    t_loop();
    t_rx();
    t_wake();
    t_brk();
    t_flip();
    results();
  end
endmodule
